// *** cct_regs.svh ***
`ifndef CCT_REGS_SVH
`define CCT_REGS_SVH
// Register byte addresses
`define CCT_ADDR_CTRL      8'h00
`define CCT_ADDR_STATUS    8'h04
`define CCT_ADDR_IRQ_EN    8'h08
`define CCT_ADDR_IRQ_CLR   8'h0c
`define CCT_ADDR_CAPTURE   8'h10
`define CCT_ADDR_COMPARE   8'h14
`define CCT_ADDR_COUNT     8'h18
`define CCT_ADDR_POWER     8'h1c
// Control field positions
`define CCT_BIT_CAP_IE     7
`define CCT_BIT_CMP_IE     6
`define CCT_BIT_OVF_IE     5
`define CCT_BIT_EDGE       1
`define CCT_BIT_LEVEL      0
// Status and event bit positions
`define CCT_EV_CAP         0
`define CCT_EV_CMP         1
`define CCT_EV_OVF         2
// Reset values and counts
`define CCT_CTRL_RESET     8'h00
`define CCT_COUNT_RESET    16'hfffc
`define CCT_COMPARE_RESET  16'hffff
`define CCT_PRESCALE       4
`endif

// *** cct_pkg.sv ***
package cct_pkg;
  // Control register fields
  typedef struct packed {
    logic       cap_ie;
    logic       cmp_ie;
    logic       ovf_ie;
    logic [2:0] unused;
    logic       edge_sel;
    logic       out_level;
  } cct_ctrl_t;
  // Low-power state
  typedef enum logic [1:0] {CCT_RUN, CCT_WAIT, CCT_STOP} cct_pmode_t;
  // Flag group
  typedef struct packed {
    logic ovf;
    logic cmp;
    logic cap;
  } cct_flags_t;
endpackage : cct_pkg

// *** cct_sync.sv ***
`timescale 1ns/10ps
module cct_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  // Two-stage synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : cct_sync

// *** cct_edge.sv ***
`timescale 1ns/10ps
module cct_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lvl_i,
  input  wire logic rise_sel_i,
  output logic      hit_o
);
  logic prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) prev_r <= 1'b0;
    else       prev_r <= lvl_i;
  end
  assign hit_o = rise_sel_i ? (lvl_i & ~prev_r) : (~lvl_i & prev_r);
endmodule : cct_edge

// *** cct_timer.sv ***
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "cct_regs.svh"
module cct_timer
  import cct_pkg::*;
#(
  parameter int PRESCALE = `CCT_PRESCALE
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        capture_input_pin_i,
  output logic             compare_output_pin_o,
  input  wire logic        wait_req_i,
  input  wire logic        stop_req_i,
  input  wire logic        ext_irq_i,
  output logic             wake_o,
  output logic             irq_o
);

  // Prescaler must fit the 8-bit divider
  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
    $error("PRESCALE out of range");
  end

  // Module state, apart from the u_sync and u_edge flops
  typedef struct packed {
    cct_ctrl_t   ctrl;
    cct_flags_t  flags;
    cct_pmode_t  pmode;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] compare;
    logic [7:0]  pre;
    logic        pend_cap;
    logic        pin_level;
    logic        ack;
    logic [31:0] rdata;
  } cct_state_t;

  cct_state_t st_r;
  cct_state_t st_nxt;

  logic cap_sync;
  logic cap_hit;
  logic tick;
  logic bus_req;
  logic bus_wr;
  logic cmp_hit;
  logic ovf_hit;
  cct_flags_t live;

  // Capture pin into clock domain
  cct_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (capture_input_pin_i),
    .q_o   (cap_sync)
  );

  // Selected edge detector
  cct_edge u_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .lvl_i      (cap_sync),
    .rise_sel_i (st_r.ctrl.edge_sel),
    .hit_o      (cap_hit)
  );

  // Bus request decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  assign tick    = (st_r.pre == 8'(PRESCALE - 1)) && (st_r.pmode != CCT_STOP);
  assign cmp_hit = tick && (st_r.count == st_r.compare);
  assign ovf_hit = tick && (st_r.count == 16'hffff);

  // Flags gated by their enables
  // OR of enabled flags
  assign live  = st_r.flags & {st_r.ctrl.ovf_ie, st_r.ctrl.cmp_ie, st_r.ctrl.cap_ie};
  // combined capture, compare and overflow interrupt
  // Enable register aliases the control enables, so a cleared enable always masks
  assign irq_o = |live;
  assign wake_o = (st_r.pmode == CCT_WAIT) && irq_o;

  assign compare_output_pin_o = st_r.pin_level;
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

  // Next-state logic
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = bus_req;
    // Flag clear first, so any event below wins
    if (bus_wr && (wb_adr_i == `CCT_ADDR_IRQ_CLR)) begin
      st_nxt.flags = st_r.flags & ~wb_dat_i[2:0];
    end
    // Prescaler
    // one count per PRESCALE clocks
    if (st_r.pmode != CCT_STOP) begin
      st_nxt.pre = tick ? 8'h00 : st_r.pre + 8'h01;
    end
    if (tick) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
    if (ovf_hit) begin
      st_nxt.flags.ovf = 1'b1;
    end
    if (cmp_hit) begin
      st_nxt.flags.cmp = 1'b1;
      st_nxt.pin_level = st_r.ctrl.out_level;
    end
    // Capture or remember during stop
    // capture on each selected edge
    if (cap_hit) begin
      st_nxt.capture = st_r.count;
      if (st_r.pmode == CCT_STOP) begin
        st_nxt.pend_cap = 1'b1;
      end else begin
        st_nxt.flags.cap = 1'b1;
      end
    end
    // Power mode sequencing
    case (st_r.pmode)
      CCT_RUN: begin
        if (stop_req_i)      st_nxt.pmode = CCT_STOP;
        else if (wait_req_i) st_nxt.pmode = CCT_WAIT;
      end
      CCT_WAIT: begin
        if (irq_o || ext_irq_i) st_nxt.pmode = CCT_RUN;
      end
      CCT_STOP: begin
        if (ext_irq_i) begin
          st_nxt.pmode    = CCT_RUN;
          st_nxt.pend_cap = 1'b0;
          if (st_r.pend_cap || cap_hit) st_nxt.flags.cap = 1'b1;
        end
      end
      default: st_nxt.pmode = CCT_RUN;
    endcase
    // Register writes
    if (bus_wr) begin
      case (wb_adr_i)
        `CCT_ADDR_CTRL: begin
          st_nxt.ctrl        = wb_dat_i[7:0];
          st_nxt.ctrl.unused = 3'b000;
        end
        // Enable register is a second view of the control enables
        `CCT_ADDR_IRQ_EN: begin
          st_nxt.ctrl.ovf_ie = wb_dat_i[`CCT_EV_OVF];
          st_nxt.ctrl.cmp_ie = wb_dat_i[`CCT_EV_CMP];
          st_nxt.ctrl.cap_ie = wb_dat_i[`CCT_EV_CAP];
        end
        // Flag clear handled ahead of the events
        `CCT_ADDR_IRQ_CLR: ;
        `CCT_ADDR_COMPARE: begin
          if (wb_sel_i[1]) st_nxt.compare = {wb_dat_i[15:8], wb_dat_i[7:0]};
          else             st_nxt.compare[7:0] = wb_dat_i[7:0];
        end
        default: ;
      endcase
    end
    // Read data
    st_nxt.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `CCT_ADDR_CTRL:    st_nxt.rdata = {24'h000000, st_r.ctrl};
        `CCT_ADDR_STATUS:  st_nxt.rdata = {29'h0, st_r.flags};
        `CCT_ADDR_IRQ_EN:  st_nxt.rdata = {29'h0, st_r.ctrl.ovf_ie, st_r.ctrl.cmp_ie,
                                           st_r.ctrl.cap_ie};
        `CCT_ADDR_CAPTURE: st_nxt.rdata = {16'h0000, st_r.capture};
        `CCT_ADDR_COMPARE: st_nxt.rdata = {16'h0000, st_r.compare};
        `CCT_ADDR_COUNT:   st_nxt.rdata = {16'h0000, st_r.count};
        `CCT_ADDR_POWER:   st_nxt.rdata = {30'h0, st_r.pmode};
        default:           st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= '0;
      st_r.ctrl    <= `CCT_CTRL_RESET;
      st_r.count   <= `CCT_COUNT_RESET;
      st_r.compare <= `CCT_COMPARE_RESET;
      st_r.pmode   <= CCT_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Assertions
  a_cap_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.flags.cap && st_r.ctrl.cap_ie) |-> irq_o)
    else $error("capture interrupt missing");
  a_cmp_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.flags.cmp && st_r.ctrl.cmp_ie) |-> irq_o)
    else $error("compare interrupt missing");
  a_ovf_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.flags.ovf && st_r.ctrl.ovf_ie) |-> irq_o)
    else $error("overflow interrupt missing");
  a_irq_or_form: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(st_r.flags & {st_r.ctrl.ovf_ie, st_r.ctrl.cmp_ie, st_r.ctrl.cap_ie}))
    else $error("interrupt not OR of enabled flags");
  a_ctrl_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ctrl.unused == 3'b000)
    else $error("unused control bits nonzero");
  a_stop_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pmode == CCT_STOP && $past(st_r.pmode) == CCT_STOP) |-> $stable(st_r.count))
    else $error("count moved in stop");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && PRESCALE == 4) |=> !tick [*3])
    else $error("counter ticks too often");
  a_cmp_drives_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_hit |=> (compare_output_pin_o == $past(st_r.ctrl.out_level)) && st_r.flags.cmp)
    else $error("compare level not driven");
  a_ovf_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_hit |=> st_r.flags.ovf && st_r.count == 16'h0000)
    else $error("overflow flag not set");
  a_wait_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pmode == CCT_WAIT && irq_o) |=> st_r.pmode == CCT_RUN)
    else $error("wait not exited");
  a_reset_count: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> st_r.count == 16'hfffc && st_r.ctrl == 8'h00)
    else $error("reset values wrong");
  a_cap_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_hit && st_r.pmode != CCT_STOP)
    |=> st_r.flags.cap && (st_r.capture == $past(st_r.count)))
    else $error("capture not taken");
  a_stop_cap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pmode == CCT_STOP && ext_irq_i && (st_r.pend_cap || cap_hit)) |=> st_r.flags.cap)
    else $error("pending capture flag lost");
  a_stop_resume: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pmode == CCT_STOP && ext_irq_i) |=> st_r.pmode == CCT_RUN && $stable(st_r.count))
    else $error("stop exit lost count");
  a_wait_counts: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pmode == CCT_WAIT && tick) |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("count stalled in wait");

  c_capture_seen: cover property (@(posedge clk_i) disable iff (rst_i) cap_hit);
  c_compare_seen: cover property (@(posedge clk_i) disable iff (rst_i) cmp_hit);
  c_overflow_seen: cover property (@(posedge clk_i) disable iff (rst_i) ovf_hit);
  c_stop_exit: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r.pmode == CCT_STOP ##1 st_r.pmode == CCT_RUN);
  c_wait_exit: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r.pmode == CCT_WAIT ##1 st_r.pmode == CCT_RUN);

endmodule : cct_timer

// *** cct_core.sv ***
`timescale 1ns/10ps
// Core-side master of the timer register bus
module cct_core (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  output logic             cyc_o = 1'b0,
  output logic             we_o  = 1'b0,
  output logic [7:0]       adr_o = 8'h00,
  output logic [31:0]      dat_o = 32'h0
);
  // One classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    dat_o <= ~d;  // Released data stops showing the word
    @(posedge clk_i);
  endtask : xfer
endmodule : cct_core

// *** test_cct_timer.sv ***
`timescale 1ns/10ps
`include "cct_regs.svh"
module test_cct_timer
  import cct_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin   = 1'b0;
  logic        woke  = 1'b0;  // Wake seen since start
  logic [2:0]  req   = 3'h0;  // Wait, stop, external wake
  logic        cyc, we, ack, cpin, wake, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q, v;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          tmo        = 0;

  // Timer and core model
  cct_timer #(.PRESCALE(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .capture_input_pin_i(pin),
    .compare_output_pin_o(cpin), .wait_req_i(req[0]),
    .stop_req_i(req[1]), .ext_irq_i(req[2]), .wake_o(wake), .irq_o(irq)
  );
  cct_core core (
    .clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .we_o(we),
    .adr_o(adr), .dat_o(wdat)
  );

  always #50 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    tmo <= tmo + 1;
    if (tmo == 4000) begin
      n_mismatch++;
      close_out;
    end
  end

  // Latch a wake request, which lasts one cycle
  always @(posedge clk_i) begin
    if (wake === 1'b1) woke <= 1'b1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    core.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic getc;
    core.xfer(1'b0, `CCT_ADDR_COUNT, 32'h0, v);
  endtask : getc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task pulse(input int k);
    req[k] <= 1'b1;
    tick(1);
    req[k] <= 1'b0;
  endtask : pulse

  task automatic t_reg;
    rc(`CCT_ADDR_COUNT, 32'hfffc);
    rc(`CCT_ADDR_CTRL, 32'h0);
    wr(`CCT_ADDR_CTRL, 32'hff);
    rc(`CCT_ADDR_CTRL, 32'he3);
    tick(20);
    rc(`CCT_ADDR_STATUS, 32'h6);
    chk("pin", 32'h1, 32'(cpin));
    chk("irq", 32'h1, 32'(irq));
    wr(`CCT_ADDR_CTRL, 32'h03);
    chk("irq", 32'h0, 32'(irq));
    wr(`CCT_ADDR_IRQ_EN, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    wr(`CCT_ADDR_IRQ_EN, 32'h0);
    wr(`CCT_ADDR_IRQ_CLR, 32'h7);
    rc(`CCT_ADDR_STATUS, 32'h0);
    rc(8'hfc, 32'h0);
    getc;
    tick(40);
    // The two count reads are taken 44 clocks apart
    rc(`CCT_ADDR_COUNT, v + 32'(44 / `CCT_PRESCALE));
    $display("t_reg done");
  endtask : t_reg

  task automatic t_cmp;
    wr(`CCT_ADDR_CTRL, 32'h40);
    getc;
    wr(`CCT_ADDR_COMPARE, {16'h0, v[15:0] + 16'h14});
    chk("pin", 32'h1, 32'(cpin));
    tick(100);
    rc(`CCT_ADDR_STATUS, 32'h2);
    chk("pin", 32'h0, 32'(cpin));
    chk("irq", 32'h1, 32'(irq));
    wr(`CCT_ADDR_CTRL, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(`CCT_ADDR_IRQ_CLR, 32'h7);
    $display("t_cmp done");
  endtask : t_cmp

  task automatic edge_chk(input logic l, input logic e);
    pin <= l;
    tick(10);
    rc(`CCT_ADDR_STATUS, 32'(e));
    chk("irq", 32'(e), 32'(irq));
    if (e) begin
      // Capture taken 13 clocks before the count read
      getc;
      core.xfer(1'b0, `CCT_ADDR_CAPTURE, 32'h0, q);
      chk("capture", 32'h1, 32'((v - q >= 32'h3) && (v - q <= 32'h4)));
    end
    wr(`CCT_ADDR_IRQ_CLR, 32'h7);
  endtask : edge_chk
  task automatic t_cap;
    wr(`CCT_ADDR_CTRL, 32'h82);
    edge_chk(1'b1, 1'b1);
    edge_chk(1'b0, 1'b0);
    wr(`CCT_ADDR_CTRL, 32'h80);
    edge_chk(1'b1, 1'b0);
    edge_chk(1'b0, 1'b1);
    $display("t_cap done");
  endtask : t_cap

  task automatic t_wait;
    wr(`CCT_ADDR_CTRL, 32'h02);
    pulse(0);
    rc(`CCT_ADDR_POWER, {30'h0, CCT_WAIT});
    getc;
    pin <= 1'b1;
    tick(40);
    rc(`CCT_ADDR_COUNT, v + 32'(44 / `CCT_PRESCALE));
    chk("wake", 32'h0, 32'(wake));
    wr(`CCT_ADDR_CTRL, 32'h82);
    chk("wake", 32'h1, 32'(woke));
    pulse(2);
    rc(`CCT_ADDR_POWER, {30'h0, CCT_RUN});
    rc(`CCT_ADDR_STATUS, 32'h1);
    wr(`CCT_ADDR_IRQ_CLR, 32'h7);
    $display("t_wait done");
  endtask : t_wait

  task automatic t_stop;
    wr(`CCT_ADDR_CTRL, 32'h00);
    pulse(1);
    getc;
    pin <= 1'b0;
    tick(40);
    rc(`CCT_ADDR_COUNT, v);
    rc(`CCT_ADDR_STATUS, 32'h0);
    pulse(2);
    tick(2);
    rc(`CCT_ADDR_STATUS, 32'h1);
    core.xfer(1'b0, `CCT_ADDR_COUNT, 32'h0, q);
    chk("resume", 32'h1, 32'(q - v < 32'h4));
    wr(`CCT_ADDR_CTRL, 32'he0);
    pulse(1);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    rc(`CCT_ADDR_COUNT, 32'hfffc);
    rc(`CCT_ADDR_CTRL, 32'h0);
    $display("t_stop done");
  endtask : t_stop

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    tick(6);
    rst_i <= 1'b0;
    t_reg;
    t_cmp;
    t_cap;
    t_wait;
    t_stop;
    close_out;
  end
endmodule : test_cct_timer
